// ===== design/cct_timer.sv
// Purpose: 8-bit free-running timer with two captures and two compares
// Assumes: strobes from the cpu side are one-cycle pulses on clk
// Notes: waveform generation of single-pulse and pwm modes is not here
`timescale 1ns/1ps
module cct_timer
    import cct_pkg::*;
#(
    parameter int OSC_DIV = CCT_OSC_DIV
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic osc_clk,
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    input wire logic [1:0] clock_select_field,
    input wire logic capture_edge_select_one,
    input wire logic capture_edge_select_two,
    input wire logic overflow_irq_enable,
    input wire logic capture_irq_enable,
    input wire logic compare_irq_enable,
    input wire logic [1:0] compare_output_enable,
    input wire logic [1:0] compare_output_level,
    input wire logic single_pulse_select,
    input wire logic pwm_select,
    input wire logic status_read,
    input wire logic counter_primary_read,
    input wire logic counter_primary_write,
    input wire logic counter_alternate_write,
    input wire logic [1:0] capture_read,
    input wire logic [1:0] compare_read,
    input wire logic [1:0] compare_write,
    input wire logic [7:0] compare_wdata,
    input wire logic capture_input_one,
    input wire logic capture_input_two,
    output logic [7:0] counter_value_primary,
    output logic [7:0] counter_value_alternate,
    output logic [7:0] capture_value_one,
    output logic [7:0] capture_value_two,
    output logic [7:0] compare_value_one,
    output logic [7:0] compare_value_two,
    output logic [7:0] timer_status_reg,
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_output_pin_oe,
    output logic timer_irq
);
    localparam int OSC_W = $clog2(OSC_DIV);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [2:0] pre_last(input logic [1:0] sel);
        logic [2:0] r;
        r = CCT_PRE_LAST8;
        if (sel == CCT_SEL_DIV2) begin
            r = CCT_PRE_LAST2;
        end else if (sel == CCT_SEL_DIV4) begin
            r = CCT_PRE_LAST4;
        end
        return r;
    endfunction

    // slower clocks see the match one count late
    function automatic logic [7:0] cmp_target(input logic [7:0] cmp, input logic [1:0] sel);
        logic [7:0] r;
        r = cmp + 8'h01;
        if (sel == CCT_SEL_DIV2) begin
            r = cmp;
        end
        return r;
    endfunction

    logic [7:0] cnt;
    logic [2:0] pre;
    logic [OSC_W-1:0] osc_cnt;
    logic osc_rise;
    logic osc_fire;
    logic tick;
    logic cnt_reload;
    logic cnt_new;
    logic ovf_set;
    logic edge_one;
    logic edge_two;
    logic cap_evt_one;
    logic cap_evt_two;
    logic [7:0] cmp_val [2];
    logic [1:0] match;
    logic [1:0] cmp_set;
    logic ovf_flag;
    logic cap_flag_one;
    logic cap_flag_two;
    logic [1:0] cmp_flag;
    logic waveform_mode;

    assign cnt_reload = counter_primary_write | counter_alternate_write;
    assign waveform_mode = single_pulse_select | pwm_select;

    // --------------------------------------------------------------
    // prescaler
    // --------------------------------------------------------------
    // oscillator is foreign to clk, so it passes the synchroniser
    cct_sync_edge u_osc_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(osc_clk),
        .rising_sel(CCT_EDGE_RISING),
        .edge_pulse(osc_rise)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre <= 3'h0;
        end else if (halt_mode) begin
            pre <= pre;
        end else if (clock_select_field == CCT_SEL_OSC || pre == pre_last(clock_select_field)) begin
            pre <= 3'h0;
        end else begin
            pre <= pre + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_cnt <= '0;
        end else if (halt_mode || clock_select_field != CCT_SEL_OSC) begin
            osc_cnt <= osc_cnt;
        end else if (osc_fire) begin
            osc_cnt <= '0;
        end else if (osc_rise) begin
            osc_cnt <= osc_cnt + OSC_W'(1);
        end
    end

    assign osc_fire = osc_rise && osc_cnt == OSC_LAST;

    always_comb begin
        if (halt_mode) begin
            tick = 1'b0;
        end else if (clock_select_field == CCT_SEL_OSC) begin
            tick = osc_fire;
        end else begin
            tick = pre == pre_last(clock_select_field);
        end
    end

    // --------------------------------------------------------------
    // counter
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= CCT_CNT_RELOAD;
        end else if (cnt_reload) begin
            cnt <= CCT_CNT_RELOAD;
        end else if (tick) begin
            cnt <= cnt + 8'h01;
        end
    end

    // marks a fresh count so each value matches once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_new <= 1'b0;
        end else begin
            cnt_new <= tick | cnt_reload;
        end
    end

    assign ovf_set = tick && !cnt_reload && cnt == CCT_CNT_TOP;
    assign counter_value_primary = cnt;
    assign counter_value_alternate = cnt;

    // --------------------------------------------------------------
    // input capture
    // --------------------------------------------------------------
    // no gating on pin direction: self-driven edges capture too
    cct_sync_edge u_cap_one (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(capture_input_one),
        .rising_sel(capture_edge_select_one),
        .edge_pulse(edge_one)
    );

    cct_sync_edge u_cap_two (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(capture_input_two),
        .rising_sel(capture_edge_select_two),
        .edge_pulse(edge_two)
    );

    assign cap_evt_one = edge_one & ~waveform_mode;
    assign cap_evt_two = edge_two;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capture_value_one <= CCT_CAP_RESET;
        end else if (cap_evt_one) begin
            capture_value_one <= cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capture_value_two <= CCT_CAP_RESET;
        end else if (cap_evt_two) begin
            capture_value_two <= cnt;
        end
    end

    // --------------------------------------------------------------
    // output compare
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_val[0] <= CCT_CMP_RESET;
            cmp_val[1] <= CCT_CMP_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (compare_write[i]) begin
                    cmp_val[i] <= compare_wdata;
                end
            end
        end
    end

    assign compare_value_one = cmp_val[0];
    assign compare_value_two = cmp_val[1];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            match[i] = cnt_new && cnt == cmp_target(cmp_val[i], clock_select_field);
        end
    end

    // pwm owns both flags, single-pulse owns channel one
    assign cmp_set[0] = match[0] & ~waveform_mode;
    assign cmp_set[1] = match[1] & ~pwm_select;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compare_output_pin <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (compare_output_enable[i] && match[i]) begin
                    compare_output_pin[i] <= compare_output_level[i];
                end
            end
        end
    end

    assign compare_output_pin_oe = compare_output_enable;

    // --------------------------------------------------------------
    // flags and interrupt
    // --------------------------------------------------------------
    cct_flag u_ovf_flag (
        .clk(clk),
        .sys_rst(sys_rst),
        .set(ovf_set),
        .status_rd(status_read),
        .reg_access(counter_primary_read | counter_primary_write),
        .flag(ovf_flag)
    );

    cct_flag u_cap_flag_one (
        .clk(clk),
        .sys_rst(sys_rst),
        .set(cap_evt_one),
        .status_rd(status_read),
        .reg_access(capture_read[0]),
        .flag(cap_flag_one)
    );

    cct_flag u_cap_flag_two (
        .clk(clk),
        .sys_rst(sys_rst),
        .set(cap_evt_two),
        .status_rd(status_read),
        .reg_access(capture_read[1]),
        .flag(cap_flag_two)
    );

    cct_flag u_cmp_flag_one (
        .clk(clk),
        .sys_rst(sys_rst),
        .set(cmp_set[0]),
        .status_rd(status_read),
        .reg_access(compare_read[0] | compare_write[0]),
        .flag(cmp_flag[0])
    );

    cct_flag u_cmp_flag_two (
        .clk(clk),
        .sys_rst(sys_rst),
        .set(cmp_set[1]),
        .status_rd(status_read),
        .reg_access(compare_read[1] | compare_write[1]),
        .flag(cmp_flag[1])
    );

    always_comb begin
        timer_status_reg = 8'h00;
        timer_status_reg[CCT_ST_CAP1] = cap_flag_one;
        timer_status_reg[CCT_ST_CMP1] = cmp_flag[0];
        timer_status_reg[CCT_ST_OVF] = ovf_flag;
        timer_status_reg[CCT_ST_CAP2] = cap_flag_two;
        timer_status_reg[CCT_ST_CMP2] = cmp_flag[1];
    end

    // level output: a pending flag fires once the mask opens
    assign timer_irq = ~cpu_irq_mask & ((ovf_flag & overflow_irq_enable)
        | ((cap_flag_one | cap_flag_two) & capture_irq_enable)
        | ((cmp_flag[0] | cmp_flag[1]) & compare_irq_enable));

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_quiet_div2;
        (clock_select_field == CCT_SEL_DIV2 && !halt_mode)[*3];
    endsequence

    sequence s_div2_start;
        tick ##0 s_quiet_div2;
    endsequence

    property p_div2_period;
        s_div2_start |-> !$past(tick) && tick;
    endproperty
    a_div2_period: assert property (p_div2_period) else $error("div2 tick spacing wrong");

    property p_reload;
        cnt_reload |=> cnt == CCT_CNT_RELOAD && cnt_new;
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");

    property p_ovf;
        ovf_set |=> ovf_flag && timer_status_reg[CCT_ST_OVF] && cnt == 8'h00;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");

    property p_halt;
        halt_mode && !cnt_reload |=> $stable(cnt);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved in halt");

    property p_capture_two;
        cap_evt_two |=> capture_value_two == $past(cnt) && cap_flag_two;
    endproperty
    a_capture_two: assert property (p_capture_two) else $error("capture two lost");

    property p_capture_one_blocked;
        waveform_mode |=> $stable(capture_value_one);
    endproperty
    a_capture_one_blocked: assert property (p_capture_one_blocked)
        else $error("capture one in waveform mode");

    property p_irq_mask;
        cpu_irq_mask |-> !timer_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq despite mask");

    property p_ovf_irq;
        ovf_flag && overflow_irq_enable && !cpu_irq_mask |-> timer_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

    property p_cmp_hold;
        !compare_write[0] |=> $stable(compare_value_one);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("compare one changed");

    property p_ovf_clear;
        $fell(ovf_flag) |-> $past(counter_primary_read | counter_primary_write);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow cleared wrongly");

    property p_pin;
        compare_output_enable[1] && match[1]
            |=> compare_output_pin[1] == $past(compare_output_level[1]);
    endproperty
    a_pin: assert property (p_pin) else $error("compare pin level wrong");

    property p_pin_reset;
        @(posedge clk) disable iff (1'b0) sys_rst |=> compare_output_pin == 2'h0;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin not low in reset");
endmodule

// ===== shared/cct_pkg.sv
// Purpose: constants shared by the 8-bit capture/compare timer
// Assumes: single 100 MHz clock, synchronous active-high reset
// Notes: status bit layout and edge-select polarity are fixed here
package cct_pkg;
    // --------------------------------------------------------------
    // counter
    // --------------------------------------------------------------
    localparam logic [7:0] CCT_CNT_RELOAD = 8'hfc;
    localparam logic [7:0] CCT_CNT_TOP = 8'hff;
    localparam logic [7:0] CCT_CMP_RESET = 8'h00;
    localparam logic [7:0] CCT_CAP_RESET = 8'h00;
    localparam int CCT_OSC_DIV = 8000;

    // --------------------------------------------------------------
    // clock select codes
    // --------------------------------------------------------------
    localparam logic [1:0] CCT_SEL_DIV2 = 2'h0;
    localparam logic [1:0] CCT_SEL_DIV4 = 2'h1;
    localparam logic [1:0] CCT_SEL_DIV8 = 2'h2;
    localparam logic [1:0] CCT_SEL_OSC = 2'h3;
    localparam logic [2:0] CCT_PRE_LAST2 = 3'h1;
    localparam logic [2:0] CCT_PRE_LAST4 = 3'h3;
    localparam logic [2:0] CCT_PRE_LAST8 = 3'h7;

    // --------------------------------------------------------------
    // status bit positions
    // --------------------------------------------------------------
    localparam int CCT_ST_CAP1 = 7;
    localparam int CCT_ST_CMP1 = 6;
    localparam int CCT_ST_OVF = 5;
    localparam int CCT_ST_CAP2 = 4;
    localparam int CCT_ST_CMP2 = 3;

    // edge select level meaning a rising edge is active
    localparam logic CCT_EDGE_RISING = 1'b1;
endpackage

// ===== design/cct_sync_edge.sv
// Purpose: two-stage synchroniser with selectable edge detect
// Assumes: input is asynchronous to clk
// Notes: edge seen two to three cycles after the pin moves
`timescale 1ns/1ps
module cct_sync_edge
    import cct_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin,
    input wire logic rising_sel,
    output logic edge_pulse
);
    logic meta;
    logic sync;
    logic sync_d;

    // --------------------------------------------------------------
    // synchroniser; meta feeds only sync
    // --------------------------------------------------------------
    // runs through reset so a pin idling high gives no false edge on release
    always_ff @(posedge clk) begin
        meta <= pin;
        sync <= meta;
        sync_d <= sync;
    end

    // --------------------------------------------------------------
    // edge detect
    // --------------------------------------------------------------
    always_comb begin
        if (rising_sel == CCT_EDGE_RISING) begin
            edge_pulse = sync & ~sync_d & ~sys_rst;
        end else begin
            edge_pulse = ~sync & sync_d & ~sys_rst;
        end
    end
endmodule

// ===== design/cct_flag.sv
// Purpose: sticky status flag with two-step clear
// Assumes: strobes are one-cycle pulses on clk
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module cct_flag (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic set,
    input wire logic status_rd,
    input wire logic reg_access,
    output logic flag
);
    logic armed;
    logic clear_now;

    // clear needs a prior status read that saw the flag set
    assign clear_now = armed & reg_access;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed <= 1'b0;
        end else if (clear_now | set) begin
            armed <= 1'b0;
        end else if (status_rd & flag) begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear_now) begin
            flag <= 1'b0;
        end
    end
endmodule

// ===== test/cct_cpu_model.sv
// Purpose: cpu-side model that clears timer flags in two steps
// Assumes: clr_req is a one-cycle pulse, clr_sel held until done
// Notes: sel 0 counter, 1/2 capture, 3/4 compare, 5 status read only
`timescale 1ns/1ps
module cct_cpu_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clr_req,
    input wire logic [2:0] clr_sel,
    output logic status_read,
    output logic counter_primary_read,
    output logic [1:0] capture_read,
    output logic [1:0] compare_read
);
    logic access;

    // --------------------------------------------------------------
    // status read, then register access one cycle later
    // --------------------------------------------------------------
    // registered so strobes move just after the edge, never mid-cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_read <= 1'b0;
            access <= 1'b0;
        end else begin
            status_read <= clr_req;
            access <= status_read;
        end
    end

    assign counter_primary_read = access && (clr_sel == 3'h0);
    assign capture_read = {access && (clr_sel == 3'h2), access && (clr_sel == 3'h1)};
    assign compare_read = {access && (clr_sel == 3'h4), access && (clr_sel == 3'h3)};
endmodule

// ===== test/cct_timer_tb_top.sv
// Purpose: self-checking bench for the capture/compare timer
// Assumes: oscillator divider shortened to 4, oscillator free running
// Notes: captures taken while halted so the latched count is exact
`timescale 1ns/1ps
module cct_timer_tb_top;
    import cct_pkg::*;
    localparam int OSC_DIV = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc_clk = 1'b0;
    logic halt_mode = 1'b0, cpu_irq_mask = 1'b0, capture_edge_select_one = 1'b1;
    logic capture_edge_select_two = 1'b0, overflow_irq_enable = 1'b0;
    logic capture_irq_enable = 1'b0, compare_irq_enable = 1'b0, single_pulse_select = 1'b0;
    logic pwm_select = 1'b0, counter_primary_write = 1'b0, counter_alternate_write = 1'b0;
    logic capture_input_one = 1'b0, capture_input_two = 1'b1, clr_req = 1'b0;
    logic [1:0] clock_select_field = 2'h0, compare_output_enable = 2'h0;
    logic [1:0] compare_output_level = 2'h0, compare_write = 2'h0;
    logic [2:0] clr_sel = 3'h0;
    logic [7:0] compare_wdata = 8'h00;
    logic status_read, counter_primary_read, timer_irq;
    logic [1:0] capture_read, compare_read, compare_output_pin, compare_output_pin_oe;
    logic [7:0] counter_value_primary, counter_value_alternate, capture_value_one;
    logic [7:0] capture_value_two, compare_value_one, compare_value_two, timer_status_reg;
    int n_mismatch = 0;
    int num_checks = 0;

    always #5 clk = ~clk;
    // seven cpu cycles per oscillator cycle, edges kept off clk edges
    initial begin
        #2;
        forever #35 osc_clk = ~osc_clk;
    end

    cct_timer #(.OSC_DIV(OSC_DIV)) DUT (
        .clk(clk), .sys_rst(sys_rst), .osc_clk(osc_clk), .halt_mode(halt_mode),
        .cpu_irq_mask(cpu_irq_mask), .clock_select_field(clock_select_field),
        .capture_edge_select_one(capture_edge_select_one),
        .capture_edge_select_two(capture_edge_select_two),
        .overflow_irq_enable(overflow_irq_enable), .capture_irq_enable(capture_irq_enable),
        .compare_irq_enable(compare_irq_enable), .compare_output_enable(compare_output_enable),
        .compare_output_level(compare_output_level), .single_pulse_select(single_pulse_select),
        .pwm_select(pwm_select), .status_read(status_read),
        .counter_primary_read(counter_primary_read),
        .counter_primary_write(counter_primary_write),
        .counter_alternate_write(counter_alternate_write), .capture_read(capture_read),
        .compare_read(compare_read), .compare_write(compare_write),
        .compare_wdata(compare_wdata), .capture_input_one(capture_input_one),
        .capture_input_two(capture_input_two), .counter_value_primary(counter_value_primary),
        .counter_value_alternate(counter_value_alternate),
        .capture_value_one(capture_value_one), .capture_value_two(capture_value_two),
        .compare_value_one(compare_value_one), .compare_value_two(compare_value_two),
        .timer_status_reg(timer_status_reg), .compare_output_pin(compare_output_pin),
        .compare_output_pin_oe(compare_output_pin_oe), .timer_irq(timer_irq));

    cct_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .clr_req(clr_req), .clr_sel(clr_sel),
        .status_read(status_read), .counter_primary_read(counter_primary_read),
        .capture_read(capture_read), .compare_read(compare_read));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic clear_flag(input logic [2:0] sel);
        clr_sel = sel;
        clr_req = 1'b1;
        tick(1);
        clr_req = 1'b0;
        tick(3);
    endtask

    task automatic print_verdict;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_overflow;
        overflow_irq_enable = 1'b1;
        cpu_irq_mask = 1'b1;
        counter_primary_write = 1'b1;
        tick(1);
        counter_primary_write = 1'b0;
        for (int i = 0; i < 30 && timer_status_reg[CCT_ST_OVF] !== 1'b1; i++) tick(1);
        chk8("ovf count", 8'h00, counter_value_primary);
        chk8("ovf flag", 8'h01, timer_status_reg[CCT_ST_OVF]);
        chk8("irq masked", 8'h00, timer_irq);
        cpu_irq_mask = 1'b0;
        tick(1);
        chk8("irq pending", 8'h01, timer_irq);
        overflow_irq_enable = 1'b0;
        tick(1);
        chk8("irq disabled", 8'h00, timer_irq);
        halt_mode = 1'b1;
        clear_flag(3'h5);
        counter_alternate_write = 1'b1;
        tick(1);
        counter_alternate_write = 1'b0;
        tick(1);
        chk8("ovf after alt", 8'h01, timer_status_reg[CCT_ST_OVF]);
        chk8("alt reload", CCT_CNT_RELOAD, counter_value_alternate);
        clear_flag(3'h0);
        chk8("ovf cleared", 8'h00, timer_status_reg[CCT_ST_OVF]);
        halt_mode = 1'b0;
    endtask

    task automatic t_period(input logic [1:0] sel);
        int n;
        n = 0;
        clock_select_field = sel;
        for (int i = 0; i < 20000 && counter_value_primary !== 8'h10; i++) tick(1);
        for (int i = 0; i < 20000 && counter_value_primary === 8'h10; i++) tick(1);
        do begin
            tick(1);
            n++;
        end while (n < 20000 && counter_value_primary !== 8'h10);
        // n misses the first count's dwell; oscillator is exactly seven clocks
        if (sel == CCT_SEL_OSC) begin
            chk8("osc period", 8'h01, 8'(n == 255 * OSC_DIV * 7));
        end else begin
            chk8("cpu period", 8'h01, 8'((n + (2 << sel)) == (512 << sel)));
        end
    endtask

    task automatic t_halt;
        logic [7:0] v;
        clock_select_field = CCT_SEL_DIV2;
        halt_mode = 1'b1;
        tick(2);
        v = counter_value_primary;
        tick(40);
        chk8("halt frozen", v, counter_value_primary);
        halt_mode = 1'b0;
        for (int i = 0; i < 10 && counter_value_primary === v; i++) tick(1);
        chk8("halt resume", v + 8'h01, counter_value_primary);
    endtask

    task automatic t_capture;
        logic [7:0] v;
        halt_mode = 1'b1;
        // drop overflow and compare flags left by the free-running tests
        clear_flag(3'h0);
        clear_flag(3'h3);
        clear_flag(3'h4);
        capture_irq_enable = 1'b1;
        counter_primary_write = 1'b1;
        tick(1);
        counter_primary_write = 1'b0;
        capture_input_one = 1'b1;
        capture_input_two = 1'b0;
        tick(6);
        chk8("cap one", CCT_CNT_RELOAD, capture_value_one);
        chk8("cap two", CCT_CNT_RELOAD, capture_value_two);
        chk8("cap flags", 8'h90, timer_status_reg);
        chk8("cap irq", 8'h01, timer_irq);
        clear_flag(3'h1);
        clear_flag(3'h2);
        chk8("cap cleared", 8'h00, timer_status_reg);
        capture_input_one = 1'b0;
        capture_input_two = 1'b1;
        tick(6);
        chk8("wrong edges", 8'h00, timer_status_reg);
        halt_mode = 1'b0;
        tick(5);
        halt_mode = 1'b1;
        tick(1);
        v = counter_value_primary;
        capture_input_two = 1'b0;
        tick(6);
        chk8("cap overwrite", v, capture_value_two);
        for (int m = 0; m < 2; m++) begin
            {pwm_select, single_pulse_select} = m ? 2'h2 : 2'h1;
            capture_input_one = 1'b1;
            tick(6);
            capture_input_one = 1'b0;
            tick(6);
            chk8("mode cap one", 8'h00, timer_status_reg[CCT_ST_CAP1]);
        end
        {pwm_select, single_pulse_select} = 2'h0;
        clear_flag(3'h2);
        capture_irq_enable = 1'b0;
        halt_mode = 1'b0;
    endtask

    task automatic t_compare(input int ch, input logic [1:0] sel, input logic [7:0] val);
        logic lv;
        lv = ~compare_output_pin[ch];
        clock_select_field = sel;
        compare_irq_enable = 1'b1;
        compare_output_enable[ch] = 1'b1;
        compare_output_level[ch] = lv;
        compare_write[ch] = 1'b1;
        compare_wdata = val;
        tick(1);
        compare_write = 2'h0;
        chk8("pin enable", compare_output_enable, compare_output_pin_oe);
        for (int i = 0; i < 3000 && compare_output_pin[ch] !== lv; i++) tick(1);
        chk8("match count", val + 8'((sel == CCT_SEL_DIV2) ? 0 : 1), counter_value_primary);
        chk8("cmp flag", 8'h01, timer_status_reg[ch ? CCT_ST_CMP2 : CCT_ST_CMP1]);
        chk8("cmp irq", 8'h01, timer_irq);
        chk8("cmp kept", val, ch ? compare_value_two : compare_value_one);
        clear_flag(3'(3 + ch));
        chk8("cmp cleared", 8'h00, timer_status_reg[ch ? CCT_ST_CMP2 : CCT_ST_CMP1]);
        compare_irq_enable = 1'b0;
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        tick(3);
        chk8("rst count", CCT_CNT_RELOAD, counter_value_primary);
        chk8("rst cmp", CCT_CMP_RESET, compare_value_one | compare_value_two);
        chk8("rst pins", 8'h00, compare_output_pin);
        chk8("rst status", 8'h00, timer_status_reg);
        tick(1);
        sys_rst = 1'b0;
        t_overflow();
        for (int s = 0; s < 4; s++) t_period(2'(s));
        t_halt();
        t_capture();
        t_compare(0, CCT_SEL_DIV2, 8'h40);
        t_compare(1, CCT_SEL_DIV4, 8'h80);
        chk8("alt view", counter_value_primary, counter_value_alternate);
        print_verdict();
    end

    initial begin
        #1_000_000;
        n_mismatch++;
        print_verdict();
    end
endmodule
